// ===== common/metering_defs.svh
`ifndef METERING_DEFS_SVH
`define METERING_DEFS_SVH

// Serial frame: 8-bit command then up to 16 data bits.
`define CMD_BITS        8
`define DATA_BITS       16
`define CMD_WRITE_BIT   7
// Command addresses (low bits of the command byte).
`define ADDR_IRQ_MASK   7'h01
`define ADDR_STATUS     7'h02
`define ADDR_PULSE_DIV  7'h03
`define ADDR_SAG_LEVEL  7'h04
`define ADDR_SAG_CYCLES 7'h05
`define ADDR_SAMPLE     7'h06
// Reset values.
`define PULSE_DIV_RST   16'h0001
`define SAG_LEVEL_RST   16'h0100
`define SAG_CYCLES_RST  16'h0004
`define IRQ_MASK_RST    3'h0
// Interrupt source bit positions.
`define IRQ_ROLLOVER    0
`define IRQ_HALF        1
`define IRQ_SAMPLE      2
// Energy accumulator width.
`define ACC_BITS        24
// Nominal master clock in Hz.
`define MCLK_HZ         3579545

`endif

// ===== common/metering_pkg.sv
package metering_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CMD  = 3'b010,
        ST_DATA = 3'b100
    } ser_state_e;
    typedef logic [15:0] word_t;
endpackage : metering_pkg

// ===== common/sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sync_if;
    logic raw_sclk;
    logic raw_cs_b;
    logic raw_din;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_b;
    logic din;
    modport sync (input raw_sclk, raw_cs_b, raw_din,
                  output sclk_rise, sclk_fall, cs_b, din);
    modport user (output raw_sclk, raw_cs_b, raw_din,
                  input sclk_rise, sclk_fall, cs_b, din);
endinterface : sync_if
`default_nettype wire

// ===== hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // Pins and edges
    sync_if.sync      s
);
    logic [2:0] meta;
    logic [2:0] stable;
    logic       sclk_prev;
    logic [2:0] next_meta;
    logic [2:0] next_stable;
    logic       next_sclk_prev;

    always_comb begin
        next_meta      = {s.raw_din, s.raw_cs_b, s.raw_sclk};
        next_stable    = meta;
        next_sclk_prev = stable[0];
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // Reset to the idle pin levels, so no false edge follows reset.
            meta      <= 3'h3;
            stable    <= 3'h3;
            sclk_prev <= 1'b1;
        end else begin
            meta      <= next_meta;
            stable    <= next_stable;
            sclk_prev <= next_sclk_prev;
        end
    end

    // Edges are taken from the second and third stages.
    assign s.sclk_rise = stable[0] & ~sclk_prev; // RL13
    assign s.sclk_fall = ~stable[0] & sclk_prev; // RL13
    assign s.cs_b      = stable[1];
    assign s.din       = stable[2];
endmodule : pin_sync
`default_nettype wire

// ===== hdl/metering_pins.sv
// Summary of operation
// RL1 - Serial port takes part only while chip select is low.
// RL2 - Data output changes on serial clock rising edge.
// RL3 - Data output undriven except while shifting read data; here it stays driven after the last read bit until deselect.
// RL4 - Data input sampled on serial clock falling edge.
// RL5 - Interrupt pin pulled low when any enabled source pending.
// RL6 - Sag pin low on missing crossings or low level too long.
// RL7 - Zero-cross output toggles at each voltage crossing.
// RL8 - Zero-cross output high on rising, low on falling crossing.
// RL9 - Energy pulse rate set by software divider value.
// RL10 - All logic timed from the master clock.
// RL11 - Reset low holds every register and the serial port reset.
// RL12 - Deselect ignores clock and data and abandons transfer.
// RL13 - Serial pins synchronised before use.
`timescale 1ns/10ps
`default_nettype none
`include "metering_defs.svh"
module metering_pins #(
    parameter int ACC_W = `ACC_BITS
) (
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_b_i,
    // Serial port
    input  wire logic                 sclk_i,
    input  wire logic                 cs_b_i,
    input  wire logic                 din_i,
    output logic                      dout_o,
    output logic                      dout_oe_o,
    // Datapath inputs
    input  wire logic                 sample_valid_i,
    input  wire metering_pkg::word_t  voltage_i,
    input  wire metering_pkg::word_t  power_i,
    // Status pins, irq and sag open drain, zero cross and pulse driven
    output logic                      irq_oe_o,
    output logic                      sag_oe_o,
    output logic                      zero_cross_out_o,
    output logic                      energy_pulse_out_o
);
    import metering_pkg::*;

    sync_if sif ();
    assign sif.raw_sclk = sclk_i;
    assign sif.raw_cs_b = cs_b_i;
    assign sif.raw_din  = din_i;
    pin_sync u_sync (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .s(sif)); // RL13

    ser_state_e         state, next_state;
    logic [4:0]         bit_cnt, next_bit_cnt;
    logic [7:0]         cmd, next_cmd;
    word_t              shreg, next_shreg;
    logic               dout, next_dout, oe, next_oe;
    word_t              pulse_div, next_pulse_div;
    word_t              sag_level, next_sag_level;
    word_t              sag_cycles, next_sag_cycles;
    logic [2:0]         irq_mask, next_irq_mask;
    logic [2:0]         status, next_status;
    word_t              last_sample, next_last_sample;
    logic [ACC_W-1:0]   acc, next_acc;
    word_t              pdiv_cnt, next_pdiv_cnt;
    logic               pulse, next_pulse;
    logic               zx, next_zx;
    word_t              low_cnt, next_low_cnt;
    word_t              nozx_cnt, next_nozx_cnt;
    logic               sag, next_sag, irq, next_irq;
    logic [ACC_W-1:0]   acc_sum;
    logic               carry;
    word_t              mag;
    logic               crossing;
    logic [2:0]         read_clear;
    word_t              rd_word;

    always_comb begin
        unique case (cmd[6:0])
            `ADDR_IRQ_MASK:   rd_word = {13'h0000, irq_mask};
            `ADDR_STATUS:     rd_word = {13'h0000, status};
            `ADDR_PULSE_DIV:  rd_word = pulse_div;
            `ADDR_SAG_LEVEL:  rd_word = sag_level;
            `ADDR_SAG_CYCLES: rd_word = sag_cycles;
            `ADDR_SAMPLE:     rd_word = last_sample;
            default:          rd_word = 16'h0000;
        endcase
    end

    // Serial engine.
    always_comb begin
        next_state      = state;
        next_bit_cnt    = bit_cnt;
        next_cmd        = cmd;
        next_shreg      = shreg;
        next_dout       = dout;
        next_oe         = oe;
        next_pulse_div  = pulse_div;
        next_sag_level  = sag_level;
        next_sag_cycles = sag_cycles;
        next_irq_mask   = irq_mask;
        read_clear      = 3'h0;
        if (sif.cs_b) begin // RL12
            next_state   = ST_IDLE;
            next_bit_cnt = 5'h00;
            next_oe      = 1'b0; // RL3
        end else begin // RL1
            unique case (state)
                ST_IDLE: begin
                    next_state   = ST_CMD;
                    next_bit_cnt = 5'h00;
                end
                ST_CMD: begin
                    if (sif.sclk_fall) begin // RL4
                        next_cmd     = {cmd[6:0], sif.din};
                        next_bit_cnt = bit_cnt + 5'h01;
                        if (bit_cnt == 5'(`CMD_BITS - 1)) begin
                            next_state   = ST_DATA;
                            next_bit_cnt = 5'h00;
                            next_shreg   = 16'h0000;
                        end
                    end
                end
                ST_DATA: begin
                    if (!cmd[`CMD_WRITE_BIT]) begin
                        if (sif.sclk_rise) begin // RL2
                            next_oe = 1'b1; // RL3
                            next_dout = (bit_cnt == 5'h00) ? rd_word[15]
                                                           : shreg[15];
                            next_shreg = (bit_cnt == 5'h00)
                                       ? {rd_word[14:0], 1'b0}
                                       : {shreg[14:0], 1'b0};
                            if (bit_cnt == 5'h00 &&
                                cmd[6:0] == `ADDR_STATUS) begin
                                read_clear = status;
                            end
                        end
                        if (sif.sclk_fall) begin
                            next_bit_cnt = bit_cnt + 5'h01;
                            if (bit_cnt == 5'(`DATA_BITS - 1)) begin
                                next_state = ST_IDLE;
                            end
                        end
                    end else if (sif.sclk_fall) begin // RL4
                        next_shreg   = {shreg[14:0], sif.din};
                        next_bit_cnt = bit_cnt + 5'h01;
                        if (bit_cnt == 5'(`DATA_BITS - 1)) begin
                            next_state = ST_IDLE;
                            unique case (cmd[6:0])
                                `ADDR_IRQ_MASK:
                                    next_irq_mask = next_shreg[2:0];
                                `ADDR_PULSE_DIV: // RL9
                                    next_pulse_div = next_shreg;
                                `ADDR_SAG_LEVEL:  next_sag_level = next_shreg;
                                `ADDR_SAG_CYCLES:
                                    next_sag_cycles = next_shreg;
                                default: ;
                            endcase
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    // Energy, zero crossing and sag, all on the master clock.
    always_comb begin // RL10
        {carry, acc_sum} = {1'b0, acc} + {{(ACC_W-16){1'b0}}, power_i};
        mag = voltage_i[15] ? 16'(~voltage_i + 16'h0001) : voltage_i;
        next_acc         = acc;
        next_last_sample = last_sample;
        next_zx          = zx;
        next_pulse       = 1'b0;
        next_pdiv_cnt    = pdiv_cnt;
        next_low_cnt     = low_cnt;
        next_nozx_cnt    = nozx_cnt;
        crossing         = 1'b0;
        // Sources set after the read clear so a new event wins.
        next_status      = status & ~read_clear;
        if (sample_valid_i) begin
            next_acc         = acc_sum;
            next_last_sample = voltage_i;
            next_status[`IRQ_SAMPLE] = 1'b1; // RL5
            if (carry) next_status[`IRQ_ROLLOVER] = 1'b1;
            if (acc_sum[ACC_W-1] && !acc[ACC_W-1]) begin
                next_status[`IRQ_HALF] = 1'b1;
            end
            if (voltage_i[15] == zx) begin // RL7
                next_zx  = ~voltage_i[15]; // RL8
                crossing = 1'b1;
            end
            next_low_cnt  = (mag < sag_level) ? low_cnt + 16'h0001 : 16'h0000;
            next_nozx_cnt = crossing ? 16'h0000 : nozx_cnt + 16'h0001;
            if (power_i != 16'h0000) begin
                if (pdiv_cnt >= pulse_div - 16'h0001) begin // RL9
                    next_pdiv_cnt = 16'h0000;
                    next_pulse    = 1'b1;
                end else begin
                    next_pdiv_cnt = pdiv_cnt + 16'h0001;
                end
            end
        end
        next_sag = (next_low_cnt >= sag_cycles) ||
                   (next_nozx_cnt >= sag_cycles); // RL6
        next_irq = |(status & irq_mask); // RL5
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin // RL11
            state       <= ST_IDLE;
            bit_cnt     <= 5'h00;
            cmd         <= 8'h00;
            shreg       <= 16'h0000;
            dout        <= 1'b0;
            oe          <= 1'b0;
            pulse_div   <= `PULSE_DIV_RST;
            sag_level   <= `SAG_LEVEL_RST;
            sag_cycles  <= `SAG_CYCLES_RST;
            irq_mask    <= `IRQ_MASK_RST;
            status      <= 3'h0;
            last_sample <= 16'h0000;
            acc         <= '0;
            pdiv_cnt    <= 16'h0000;
            pulse       <= 1'b0;
            zx          <= 1'b0;
            low_cnt     <= 16'h0000;
            nozx_cnt    <= 16'h0000;
            sag         <= 1'b0;
            irq         <= 1'b0;
        end else begin
            state       <= next_state;
            bit_cnt     <= next_bit_cnt;
            cmd         <= next_cmd;
            shreg       <= next_shreg;
            dout        <= next_dout;
            oe          <= next_oe;
            pulse_div   <= next_pulse_div;
            sag_level   <= next_sag_level;
            sag_cycles  <= next_sag_cycles;
            irq_mask    <= next_irq_mask;
            status      <= next_status;
            last_sample <= next_last_sample;
            acc         <= next_acc;
            pdiv_cnt    <= next_pdiv_cnt;
            pulse       <= next_pulse;
            zx          <= next_zx;
            low_cnt     <= next_low_cnt;
            nozx_cnt    <= next_nozx_cnt;
            sag         <= next_sag;
            irq         <= next_irq;
        end
    end

    assign dout_o             = dout;
    assign dout_oe_o          = oe;
    assign irq_oe_o           = irq;
    assign sag_oe_o           = sag;
    assign zero_cross_out_o   = zx;
    assign energy_pulse_out_o = pulse;

    dout_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        sif.cs_b |=> !oe) else $error("dout driven while deselected"); // RL3
    dout_edge_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (oe && $changed(dout)) |-> $past(sif.sclk_rise))
        else $error("dout changed off rising edge"); // RL2
    idle_deselect_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        sif.cs_b |=> state == ST_IDLE)
        else $error("transfer kept while deselected"); // RL12
    irq_mask_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        |(status & irq_mask) |=> irq) else $error("irq not raised"); // RL5
    irq_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !(|(status & irq_mask)) |=> !irq) else $error("irq stuck"); // RL5
    zx_up_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (sample_valid_i && !voltage_i[15]) |=> zx)
        else $error("zero cross not high"); // RL8
    zx_down_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (sample_valid_i && voltage_i[15]) |=> !zx)
        else $error("zero cross not low"); // RL7
    sag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (low_cnt >= sag_cycles) |-> sag) else $error("sag missing"); // RL6
    pulse_one_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        pulse |=> !pulse) else $error("pulse too long"); // RL9
endmodule : metering_pins
`default_nettype wire

// ===== test/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
    import metering_pkg::*;
(
    // Master clock paces the serial edges and samples the data line
    input  wire logic clk_sys_i,
    // Serial pins as seen by the host
    output logic      sclk_o,
    output logic      cs_b_o,
    output logic      din_o,
    input  wire logic dout_i,
    input  wire logic dout_oe_i
);
    // Each serial clock half lasts 16 ns, four master clock cycles.
    localparam int HALF = 4;
    logic dout_last;
    logic dout_line;

    initial begin
        sclk_o    = 1'b1;
        cs_b_o    = 1'b1;
        din_o     = 1'b0;
        dout_last = 1'b0;
    end

    // An undriven data line must not look like the last bit sent.
    always @(posedge clk_sys_i) begin
        if (dout_oe_i === 1'b1) begin
            dout_last <= dout_i;
        end
    end
    assign dout_line = (dout_oe_i === 1'b1) ? dout_i : ~dout_last;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick

    // Shifts nedges bits of command and data; fewer than 24 abandons.
    task automatic xfer(input logic [7:0] cmd, input word_t wr,
                        input int nedges, output word_t rd,
                        output logic oe_seen);
        logic [23:0] frame;
        frame   = {cmd, wr};
        rd      = '0;
        oe_seen = 1'b0;
        tick(1);
        cs_b_o = 1'b0;
        tick(HALF);
        for (int i = 0; i < nedges; i++) begin
            din_o = frame[23-i];
            tick(HALF);
            sclk_o = 1'b0;
            tick(HALF);
            if (i >= 8) begin
                rd[23-i] = dout_line;
            end
            if (i == 8) begin
                oe_seen = dout_oe_i;
            end
            sclk_o = 1'b1;
        end
        tick(2 * HALF);
        cs_b_o = 1'b1;
        din_o  = ~din_o;
        tick(HALF);
    endtask : xfer
endmodule : host_model
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "metering_defs.svh"
module tb_top;
    import metering_pkg::*;
    logic  clk_sys_i;
    logic  rst_b_i;
    logic  sclk;
    logic  cs_b;
    logic  din;
    logic  dout;
    logic  dout_oe;
    logic  sample_valid;
    word_t voltage;
    word_t power;
    logic  irq_oe;
    logic  sag_oe;
    logic  zx;
    logic  pulse;
    int    miscompares;
    int    num_checks;
    int    pulse_count;
    word_t rd;
    logic  oe;

    metering_pins u_metering_pins (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
        .cs_b_i(cs_b), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
        .sample_valid_i(sample_valid), .voltage_i(voltage),
        .power_i(power), .irq_oe_o(irq_oe), .sag_oe_o(sag_oe),
        .zero_cross_out_o(zx), .energy_pulse_out_o(pulse));

    host_model u_host_model (
        .clk_sys_i(clk_sys_i), .sclk_o(sclk), .cs_b_o(cs_b),
        .din_o(din), .dout_i(dout), .dout_oe_i(dout_oe));

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // Counted on the falling edge, away from the edge that launches it.
    always @(negedge clk_sys_i) begin
        if (pulse === 1'b1) begin
            pulse_count++;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick

    task automatic check(input string name, input word_t exp,
                         input word_t got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr_reg(input logic [6:0] addr, input word_t data);
        u_host_model.xfer({1'b1, addr}, data, 24, rd, oe);
    endtask : wr_reg

    task automatic rd_reg(input logic [6:0] addr, input word_t exp,
                          input string name);
        u_host_model.xfer({1'b0, addr}, 16'h0000, 24, rd, oe);
        check(name, exp, rd);
        check("read data enable", 16'h0001, {15'h0000, oe});
        tick(4);
        check("released data enable", 16'h0000, {15'h0000, dout_oe});
    endtask : rd_reg

    task automatic put_sample(input word_t v, input word_t p);
        sample_valid = 1'b1;
        voltage      = v;
        power        = p;
        tick(1);
        sample_valid = 1'b0;
        tick(3);
    endtask : put_sample

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic t_reset;
        rst_b_i = 1'b0;
        tick(6);
        check("outputs in reset", 16'h0000,
              {10'h000, dout, dout_oe, irq_oe, sag_oe, zx, pulse});
        rst_b_i = 1'b1;
        tick(4);
    endtask : t_reset

    task automatic t_regs;
        rd_reg(`ADDR_PULSE_DIV, `PULSE_DIV_RST, "divider reset");
        rd_reg(`ADDR_SAG_LEVEL, `SAG_LEVEL_RST, "sag level reset");
        rd_reg(`ADDR_SAG_CYCLES, `SAG_CYCLES_RST, "sag cycles");
        wr_reg(`ADDR_PULSE_DIV, 16'h0003);
        check("enable in write", 16'h0000, {15'h0000, oe});
        rd_reg(`ADDR_PULSE_DIV, 16'h0003, "divider");
    endtask : t_regs

    task automatic t_pulse;
        pulse_count = 0;
        for (int i = 0; i < 6; i++) begin
            put_sample(16'h4000, 16'h0001);
        end
        tick(3);
        check("pulse count", 16'h0002, 16'(pulse_count));
    endtask : t_pulse

    task automatic t_abort;
        u_host_model.xfer({1'b1, `ADDR_SAG_LEVEL}, 16'h00F0, 12, rd, oe);
        rd_reg(`ADDR_SAG_LEVEL, `SAG_LEVEL_RST, "abandoned write");
    endtask : t_abort

    task automatic t_zero_cross;
        put_sample(16'h2000, 16'h0000);
        check("zero cross high", 16'h0001, {15'h0000, zx});
        put_sample(16'hE000, 16'h0000);
        check("zero cross low", 16'h0000, {15'h0000, zx});
        rd_reg(`ADDR_SAMPLE, 16'hE000, "last sample");
        put_sample(16'h0000, 16'h0000);
        check("zero cross zero", 16'h0001, {15'h0000, zx});
    endtask : t_zero_cross

    task automatic t_irq;
        wr_reg(`ADDR_IRQ_MASK, 16'h0000);
        u_host_model.xfer({1'b0, `ADDR_STATUS}, 16'h0000, 24, rd, oe);
        wr_reg(`ADDR_IRQ_MASK, 16'h0004);
        check("irq idle", 16'h0000, {15'h0000, irq_oe});
        put_sample(16'h1000, 16'h0000);
        check("irq raised", 16'h0001, {15'h0000, irq_oe});
        u_host_model.xfer({1'b0, `ADDR_STATUS}, 16'h0000, 24, rd, oe);
        check("status sample bit", 16'h0004, rd & 16'h0004);
        tick(3);
        check("irq cleared", 16'h0000, {15'h0000, irq_oe});
        wr_reg(`ADDR_IRQ_MASK, 16'h0000);
        put_sample(16'h1000, 16'h0000);
        check("irq masked", 16'h0000, {15'h0000, irq_oe});
    endtask : t_irq

    task automatic t_sag;
        check("sag idle", 16'h0000, {15'h0000, sag_oe});
        for (int i = 0; i < 6; i++) begin
            put_sample(16'h0010, 16'h0000);
        end
        check("sag raised", 16'h0001, {15'h0000, sag_oe});
    endtask : t_sag

    task automatic t_energy;
        u_host_model.xfer({1'b0, `ADDR_STATUS}, 16'h0000, 24, rd, oe);
        for (int i = 0; i < 130; i++) begin
            put_sample(16'h4000, 16'hFFFF);
        end
        rd_reg(`ADDR_STATUS, 16'h0006, "half level status");
        for (int i = 0; i < 130; i++) begin
            put_sample(16'h4000, 16'hFFFF);
        end
        rd_reg(`ADDR_STATUS, 16'h0005, "rollover status");
    endtask : t_energy

    initial begin
        rst_b_i      = 1'b0;
        sample_valid = 1'b0;
        voltage      = '0;
        power        = '0;
        miscompares  = 0;
        num_checks   = 0;
        pulse_count  = 0;
        t_reset();
        t_regs();
        t_pulse();
        t_abort();
        t_zero_cross();
        t_irq();
        t_sag();
        t_energy();
        print_verdict();
    end

    // A hang is cut short and counted.
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        miscompares++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
